// file: rtl/icpi_defines.vh
// Constants for the disk channel pin interface block
`ifndef ICPI_DEFINES_VH
`define ICPI_DEFINES_VH
// Transaction kinds requested by the internal engines
`define ICPI_KIND_IDLE      2'h0
`define ICPI_KIND_EXP       2'h1
`define ICPI_KIND_DISK      2'h2
// Drive register block selects, index into the four selects
`define ICPI_SEL_PRI_CTL    2'h0
`define ICPI_SEL_PRI_CMD    2'h1
`define ICPI_SEL_SEC_CTL    2'h2
`define ICPI_SEL_SEC_CMD    2'h3
// Bit positions of register address and selects on the unlatched address lines (23:17 mapped to 6:0)
`define ICPI_LA_DA_LSB      0
`define ICPI_LA_SEL_LSB     3
// Disk data bits that carry the received upper system address
`define ICPI_DD_ADDR_LSB    3
// Disk data bit that carries the interrupt-controller chip select
`define ICPI_DD_INTR_CS     14
// Timing in ns and derived cycle counts at 40 MHz
`define ICPI_CLK_NS         25
`define ICPI_SETUP_NS       70
`define ICPI_SETUP_CYC      ((`ICPI_SETUP_NS + `ICPI_CLK_NS - 1) / `ICPI_CLK_NS)
`define ICPI_STROBE_NS      165
`define ICPI_STROBE_CYC     ((`ICPI_STROBE_NS + `ICPI_CLK_NS - 1) / `ICPI_CLK_NS)
`define ICPI_HOLD_NS        30
`define ICPI_HOLD_CYC       ((`ICPI_HOLD_NS + `ICPI_CLK_NS - 1) / `ICPI_CLK_NS)
`endif

// file: rtl/icpi_sync3.v
// Three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module icpi_sync3
#(
    parameter WIDTH = 1                     // Number of bits synchronised
)
(
    input  wire             ref_clk_in,     // Core clock
    input  wire             rst_n_in,       // Asynchronous reset, active low
    input  wire [WIDTH-1:0] async_in,       // Raw pin levels
    input  wire [WIDTH-1:0] reset_val_in,   // Unused; reset always loads zero
    output reg  [WIDTH-1:0] sync_out        // Filtered level
);
    reg [WIDTH-1:0] meta_q;                 // First stage, read only by second
    reg [WIDTH-1:0] s2_q;                   // Second stage
    reg [WIDTH-1:0] s3_q;                   // Third stage

    // Shift chain; a change counts once stages two and three agree
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q   <= {WIDTH{1'b0}};
            s2_q     <= {WIDTH{1'b0}};
            s3_q     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q   <= async_in;
            s2_q     <= meta_q;
            s3_q     <= s2_q;
            // Bitwise agreement; disagreeing bits hold last value
            sync_out <= (s2_q & s3_q) | (sync_out & (s2_q ^ s3_q));
        end
    end
endmodule // icpi_sync3

// file: rtl/icpi_channel_pins.v
// Disk channel pin interface: data bus, strobes, DMA handshake, transceivers
// Contract
// - Disk data bus drives both connectors
// - Data bus also feeds address transceivers
// - Data bit 14 carries interrupt controller select
// - One read and one write strobe
// - Per-connector DMA request for bus-master only
// - Per-connector DMA acknowledge, active low
// - Active-low transceiver output enable
// - Direction rests high, transmit outward
// - External master: direction low, latch address
// - Three transceiver control states
// - Selects set up before, held through strobe
// - Address bit 23 selects secondary command
// - Address bit 22 selects secondary control
// - Address bit 21 selects primary command
// - Address bit 20 selects primary control
// - Address bits 19:17 give register address
// - Otherwise address lines keep expansion role
`timescale 1ns/1ps
`include "icpi_defines.vh"
module icpi_channel_pins
#(
    parameter SETUP_CYC  = `ICPI_SETUP_CYC,     // Select-to-strobe setup cycles
    parameter STROBE_CYC = `ICPI_STROBE_CYC,    // Minimum strobe width cycles
    parameter HOLD_CYC   = `ICPI_HOLD_CYC       // Select hold after strobe
)
(
    input  wire        ref_clk_in,              // 40 MHz core clock
    input  wire        rst_n_in,                // Asynchronous reset, active low
    // Disk register access request from the core
    input  wire        disk_req_in,             // Start one drive register access
    input  wire        disk_write_in,           // 1 write, 0 read
    input  wire [1:0]  disk_block_in,           // Which of four register blocks
    input  wire [2:0]  disk_reg_in,             // Byte within the block
    input  wire [15:0] disk_wdata_in,           // Write data
    output reg         disk_busy_out,           // Access in progress
    output reg         disk_done_out,           // One-cycle completion pulse
    output reg  [15:0] disk_rdata_out,          // Read data, valid with done
    // Expansion-bus side controls from the core
    input  wire        exp_xfer_in,             // PCI to expansion cycle in progress
    input  wire [15:0] exp_upper_in,            // Upper address and selects to send
    input  wire        exp_master_in,           // External expansion master granted
    input  wire [6:0]  exp_la_in,               // Unlatched address 23:17 from core
    output reg  [11:0] master_addr_out,         // Latched master address 19:8
    // Bus-master engine DMA handshake
    input  wire [1:0]  bm_active_in,            // Engine transferring for channel
    output reg  [1:0]  bm_request_out,          // Synchronised drive requests
    // Pins
    input  wire [15:0] disk_data_bus_in,        // Disk data bus level
    output reg  [15:0] disk_data_bus_out,       // Disk data bus drive value
    output reg         disk_data_bus_oe_out,    // High while driving the data bus
    output reg         disk_read_strobe_n_out,  // Read strobe to both connectors
    output reg         disk_write_strobe_n_out, // Write strobe to both connectors
    input  wire [1:0]  disk_dma_request_in,     // Drive DMA requests
    output reg  [1:0]  disk_dma_ack_n_out,      // DMA acknowledges, active low
    input  wire        disk_channel_ready_in,   // Shared ready from drives
    output reg         addr_xcvr_out_en_n_out,  // Transceiver enable, active low
    output reg         addr_xcvr_direction_out, // 1 transmit outward, 0 receive
    input  wire [6:0]  unlatched_address_upper_in,  // Lines 23:17 level
    output reg  [6:0]  unlatched_address_upper_out, // Lines 23:17 drive value
    output reg         unlatched_address_upper_oe_out // High while driving lines
);
    // Access sequencer states
    localparam ST_IDLE   = 3'h0;                // No drive access
    localparam ST_SETUP  = 3'h1;                // Selects out, strobe not yet
    localparam ST_STROBE = 3'h2;                // Strobe active
    localparam ST_WAIT   = 3'h3;                // Stretched by ready low
    localparam ST_HOLD   = 3'h4;                // Strobe off, selects held

    reg  [2:0]  state_q;                        // Sequencer state
    reg  [2:0]  state_d;                        // Next state
    reg  [7:0]  cnt_q;                          // Phase counter
    reg  [7:0]  cnt_d;                          // Next phase counter
    reg         write_q;                        // Captured direction
    reg  [1:0]  block_q;                        // Captured block
    reg  [2:0]  reg_q;                          // Captured register byte
    reg  [15:0] wdata_q;                        // Captured write data
    wire        ready_s;                        // Synchronised channel ready
    wire [1:0]  dreq_s;                         // Synchronised DMA requests
    wire [15:0] dd_s;                           // Synchronised data bus level
    reg  [3:0]  sel_onehot;                     // Block select one-hot
    reg         in_access;                      // Selects must be on the lines

    // Pin inputs pass three stages before use
    icpi_sync3 #(.WIDTH(19)) u_sync
    (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n_in),
        .async_in     ({disk_channel_ready_in, disk_dma_request_in, disk_data_bus_in}),
        .reset_val_in (19'h00000),
        .sync_out     ({ready_s, dreq_s, dd_s})
    );

    // Next-state logic; ready low keeps the strobe on
    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE:
            begin
                if (disk_req_in && !exp_master_in)
                begin
                    state_d = ST_SETUP;
                    cnt_d   = SETUP_CYC[7:0];
                end
            end
            ST_SETUP:
            begin
                if (cnt_q <= 8'h01)
                begin
                    state_d = ST_STROBE;
                    cnt_d   = STROBE_CYC[7:0];
                end
                else
                    cnt_d = cnt_q - 8'h01;
            end
            ST_STROBE:
            begin
                if (cnt_q <= 8'h01)
                    state_d = ST_WAIT;
                else
                    cnt_d = cnt_q - 8'h01;
            end
            ST_WAIT:
            begin
                // Drive not ready yet: stretch the cycle
                if (ready_s)
                begin
                    state_d = ST_HOLD;
                    cnt_d   = HOLD_CYC[7:0];
                end
            end
            ST_HOLD:
            begin
                if (cnt_q <= 8'h01)
                    state_d = ST_IDLE;
                else
                    cnt_d = cnt_q - 8'h01;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // One-hot select from captured block; only one can be on
    always @*
    begin
        in_access  = (state_q != ST_IDLE);
        sel_onehot = 4'h0;
        if (in_access)
            sel_onehot[block_q] = 1'b1;
    end

    // Sequencer and captured request
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 8'h00;
            write_q <= 1'b0;
            block_q <= 2'h0;
            reg_q   <= 3'h0;
            wdata_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            // Capture only at start so lines stay stable all access
            if (state_q == ST_IDLE && state_d == ST_SETUP)
            begin
                write_q <= disk_write_in;
                block_q <= disk_block_in;
                reg_q   <= disk_reg_in;
                wdata_q <= disk_wdata_in;
            end
        end
    end

    // Pin drivers, all registered
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            disk_read_strobe_n_out         <= 1'b1;
            disk_write_strobe_n_out        <= 1'b1;
            disk_data_bus_out              <= 16'h0000;
            disk_data_bus_oe_out           <= 1'b0;
            addr_xcvr_out_en_n_out         <= 1'b1;
            addr_xcvr_direction_out        <= 1'b1;
            unlatched_address_upper_out    <= 7'h00;
            unlatched_address_upper_oe_out <= 1'b0;
            disk_dma_ack_n_out             <= 2'h3;
            bm_request_out                 <= 2'h0;
            master_addr_out                <= 12'h000;
            disk_busy_out                  <= 1'b0;
            disk_done_out                  <= 1'b0;
            disk_rdata_out                 <= 16'h0000;
        end
        else
        begin
            // Strobes shared by both connectors
            disk_read_strobe_n_out  <= !((state_d == ST_STROBE || state_d == ST_WAIT)
                                         && !write_q);
            disk_write_strobe_n_out <= !((state_d == ST_STROBE || state_d == ST_WAIT)
                                         && write_q);
            disk_busy_out <= (state_d != ST_IDLE);
            disk_done_out <= (state_q == ST_HOLD && state_d == ST_IDLE);
            // Read data sampled as the strobe ends
            if (state_q == ST_WAIT && ready_s && !write_q)
                disk_rdata_out <= dd_s;
            // Unlatched lines: selects during access, expansion role otherwise
            if (state_d != ST_IDLE)
            begin
                unlatched_address_upper_out[`ICPI_LA_SEL_LSB+3] <=
                    sel_onehot[`ICPI_SEL_SEC_CMD] | (state_q == ST_IDLE
                    && disk_block_in == `ICPI_SEL_SEC_CMD);
                unlatched_address_upper_out[`ICPI_LA_SEL_LSB+2] <=
                    sel_onehot[`ICPI_SEL_SEC_CTL] | (state_q == ST_IDLE
                    && disk_block_in == `ICPI_SEL_SEC_CTL);
                unlatched_address_upper_out[`ICPI_LA_SEL_LSB+1] <=
                    sel_onehot[`ICPI_SEL_PRI_CMD] | (state_q == ST_IDLE
                    && disk_block_in == `ICPI_SEL_PRI_CMD);
                unlatched_address_upper_out[`ICPI_LA_SEL_LSB] <=
                    sel_onehot[`ICPI_SEL_PRI_CTL] | (state_q == ST_IDLE
                    && disk_block_in == `ICPI_SEL_PRI_CTL);
                unlatched_address_upper_out[`ICPI_LA_DA_LSB+2:`ICPI_LA_DA_LSB] <=
                    (state_q == ST_IDLE) ? disk_reg_in : reg_q;
                unlatched_address_upper_oe_out <= 1'b1;
            end
            else
            begin
                // External master drives the lines itself
                unlatched_address_upper_out    <= exp_la_in;
                unlatched_address_upper_oe_out <= !exp_master_in;
            end
            // Transceiver control: three legal states
            if (exp_master_in)
            begin
                addr_xcvr_out_en_n_out  <= 1'b0;
                addr_xcvr_direction_out <= 1'b0;
            end
            else if (state_d != ST_IDLE)
            begin
                addr_xcvr_out_en_n_out  <= 1'b1;
                addr_xcvr_direction_out <= 1'b1;
            end
            else
            begin
                addr_xcvr_out_en_n_out  <= !exp_xfer_in;
                addr_xcvr_direction_out <= 1'b1;
            end
            // Data bus: disk write data, or address/selects via transceivers
            if (exp_master_in)
                disk_data_bus_oe_out <= 1'b0;
            else if (state_d != ST_IDLE)
            begin
                disk_data_bus_oe_out <= (state_q == ST_IDLE) ? disk_write_in
                                                             : write_q;
                disk_data_bus_out    <= (state_q == ST_IDLE) ? disk_wdata_in
                                                             : wdata_q;
            end
            else if (exp_xfer_in)
            begin
                // Upper address, byte-high and chip selects; bit 14 is the
                // interrupt controller select
                disk_data_bus_oe_out <= 1'b1;
                disk_data_bus_out    <= exp_upper_in;
            end
            else
                disk_data_bus_oe_out <= 1'b0;
            // Receive master address 19:8 on data bits 15:4 of 15:3 window
            if (exp_master_in && !addr_xcvr_direction_out)
                master_addr_out <= dd_s[15:`ICPI_DD_ADDR_LSB+1];
            // Requests go only to the bus-master engine
            bm_request_out <= dreq_s;
            // Acknowledge needs both request and engine activity
            disk_dma_ack_n_out <= ~(dreq_s & bm_active_in);
        end
    end
endmodule // icpi_channel_pins

// file: sim/icpi_channel_pins_asserts.sv
// Concurrent checks on the disk channel pin interface ports
`timescale 1ns/1ps
module icpi_channel_pins_asserts
#(
    parameter SETUP_CYC  = 3,   // Select setup cycles
    parameter STROBE_CYC = 7,   // Minimum strobe cycles
    parameter HOLD_CYC   = 2    // Select hold cycles
)
(
    input wire        ref_clk_in,
    input wire        rst_n_in,
    input wire        disk_busy_out,
    input wire        exp_xfer_in,
    input wire        exp_master_in,
    input wire [1:0]  bm_active_in,
    input wire [1:0]  bm_request_out,
    input wire        disk_data_bus_oe_out,
    input wire        disk_read_strobe_n_out,
    input wire        disk_write_strobe_n_out,
    input wire [1:0]  disk_dma_request_in,
    input wire [1:0]  disk_dma_ack_n_out,
    input wire        disk_channel_ready_in,
    input wire        addr_xcvr_out_en_n_out,
    input wire        addr_xcvr_direction_out,
    input wire [6:0]  unlatched_address_upper_out,
    input wire        unlatched_address_upper_oe_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Low while either strobe is active
    wire       stb_n = disk_read_strobe_n_out & disk_write_strobe_n_out;
    wire [3:0] sel   = unlatched_address_upper_out[6:3];  // Four block selects
    wire       la_oe = unlatched_address_upper_oe_out;
    wire       mst   = exp_master_in;                     // External master owns bus
    a_one_strobe: assert property (disk_read_strobe_n_out | disk_write_strobe_n_out)
        else $error("both strobes low");
    a_strobe_sel: assert property (!stb_n |-> disk_busy_out && la_oe && $onehot(sel))
        else $error("strobe without exactly one select");
    a_sel_setup: assert property ($fell(stb_n) |-> $past(la_oe, 2) && $past(sel, 2) == sel)
        else $error("select not set up before strobe");
    a_strobe_width: assert property ($fell(stb_n) |-> !stb_n [*7])
        else $error("strobe too short");
    a_ready_stretch: assert property ((!stb_n && !disk_channel_ready_in) [*4] |=> !stb_n)
        else $error("strobe ended while not ready");
    a_sel_hold: assert property ($rose(stb_n) |-> (la_oe && $stable(sel)) [*2])
        else $error("select not held after strobe");
    a_disk_xcvr: assert property (disk_busy_out |->
        addr_xcvr_out_en_n_out && addr_xcvr_direction_out) else $error("xcvr on in access");
    a_exp_xcvr: assert property (exp_xfer_in [*3] |->
        !addr_xcvr_out_en_n_out && addr_xcvr_direction_out && disk_data_bus_oe_out)
        else $error("outward transfer not driven");
    a_master_turn: assert property (mst [*3] |->
        !addr_xcvr_out_en_n_out && !addr_xcvr_direction_out) else $error("xcvr not reversed");
    a_master_idle: assert property (mst && !disk_busy_out |=> !disk_busy_out)
        else $error("access started under external master");
    a_ack_grant: assert property ((disk_dma_request_in[0] && bm_active_in[0]) [*6] |->
        !disk_dma_ack_n_out[0]) else $error("acknowledge missing");
    a_ack_cause: assert property ((~disk_dma_ack_n_out &
        ~(bm_request_out & $past(bm_active_in))) == 2'h0) else $error("acknowledge without cause");
    c_read: cover property ($rose(disk_read_strobe_n_out));
    c_write: cover property ($rose(disk_write_strobe_n_out));
    c_master: cover property (mst [*3]);
    c_ack: cover property ($fell(disk_dma_ack_n_out[1]));
endmodule // icpi_channel_pins_asserts

bind icpi_channel_pins icpi_channel_pins_asserts #(.SETUP_CYC(SETUP_CYC),
    .STROBE_CYC(STROBE_CYC), .HOLD_CYC(HOLD_CYC)) u_chk (.ref_clk_in, .rst_n_in,
    .disk_busy_out, .exp_xfer_in, .exp_master_in, .bm_active_in, .bm_request_out,
    .disk_data_bus_oe_out, .disk_read_strobe_n_out, .disk_write_strobe_n_out,
    .disk_dma_request_in, .disk_dma_ack_n_out, .disk_channel_ready_in,
    .addr_xcvr_out_en_n_out, .addr_xcvr_direction_out, .unlatched_address_upper_out,
    .unlatched_address_upper_oe_out);

// file: sim/icpi_drive_model.sv
// Drives and address transceivers on the far side of the disk channel
`timescale 1ns/1ps
module icpi_drive_model
(
    input  wire        clk_in,      // Block clock
    input  wire        rd_n_in,     // Read strobe
    input  wire        wr_n_in,     // Write strobe
    input  wire [15:0] blk_data_in, // Block data drive value
    input  wire        blk_oe_in,   // Block drives the data bus
    input  wire [6:0]  la_in,       // Resolved address lines
    input  wire        en_n_in,     // Transceiver enable
    input  wire        dir_in,      // Transceiver direction
    input  wire [11:0] maddr_in,    // Address of the external master
    input  wire [2:0]  waits_in,    // Wait states per strobe
    input  wire [1:0]  dreq_in,     // Requests asked by the bench
    output wire [15:0] bus_out,     // Resolved data bus level
    output wire        ready_out,   // Shared ready, pulled up
    output wire [1:0]  dreq_out     // Per-connector requests
);
    reg [15:0] mem [0:127];         // One word per select and address
    reg [15:0] last_q = 16'h0;      // Last bus level
    reg [2:0]  cnt_q = 3'h0;        // Strobe cycles so far
    wire       stb = !(rd_n_in && wr_n_in);
    // Not ready for the set wait states, high otherwise by pull-up
    assign ready_out = !(stb && cnt_q < waits_in);
    // Each connector raises its own request line
    assign dreq_out = dreq_in;
    // Released bus toggles so a stale value never reads as valid
    assign bus_out = blk_oe_in ? blk_data_in :
                     !rd_n_in ? mem[la_in] :
                     (!en_n_in && !dir_in) ? {maddr_in, ~last_q[3:0]} : ~last_q;
    // Write data taken on every cycle of the write strobe
    always @(posedge clk_in)
    begin
        last_q <= bus_out;
        cnt_q <= stb ? cnt_q + 3'h1 : 3'h0;
        if (!wr_n_in)
        begin
            mem[la_in] <= blk_oe_in ? blk_data_in : ~last_q;
        end
    end
endmodule // icpi_drive_model

// file: sim/icpi_channel_pins_tb_top.sv
// Self-checking bench for the disk channel pin interface
`timescale 1ns/1ps
module icpi_channel_pins_tb_top;
    reg         clk, rst_n, req, wr, xfer, mst;
    reg  [1:0]  blk, act, dreq;
    reg  [2:0]  rg, waits, rr;
    reg  [15:0] wdata, upper, wd;
    reg  [6:0]  la_drv, la_ext;
    reg  [11:0] maddr;
    reg  [31:0] rnd;
    reg  [23:0] e;
    reg  [23:0] expq [$];           // Expected: write flag, model index, word
    integer     n_mismatch, n_compared, k, i;
    wire        busy, done, dbus_oe, rd_n, wr_n, ready, en_n, dir, la_oe;
    wire [15:0] rdata, dbus_o, dbus;
    wire [11:0] maddr_q;
    wire [1:0]  bm_req, ack_n, dreq_w;
    wire [6:0]  la_o;
    wire [6:0]  la = la_oe ? la_o : la_ext;  // Lines from block or external master
    icpi_channel_pins uut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .disk_req_in(req), .disk_write_in(wr),
        .disk_block_in(blk), .disk_reg_in(rg), .disk_wdata_in(wdata), .disk_busy_out(busy),
        .disk_done_out(done), .disk_rdata_out(rdata), .exp_xfer_in(xfer), .exp_upper_in(upper),
        .exp_master_in(mst), .exp_la_in(la_drv), .master_addr_out(maddr_q),
        .bm_active_in(act), .bm_request_out(bm_req), .disk_data_bus_in(dbus),
        .disk_data_bus_out(dbus_o), .disk_data_bus_oe_out(dbus_oe),
        .disk_read_strobe_n_out(rd_n), .disk_write_strobe_n_out(wr_n),
        .disk_dma_request_in(dreq_w), .disk_dma_ack_n_out(ack_n),
        .disk_channel_ready_in(ready), .addr_xcvr_out_en_n_out(en_n),
        .addr_xcvr_direction_out(dir), .unlatched_address_upper_in(la),
        .unlatched_address_upper_out(la_o), .unlatched_address_upper_oe_out(la_oe));
    icpi_drive_model u_model (
        .clk_in(clk), .rd_n_in(rd_n), .wr_n_in(wr_n), .blk_data_in(dbus_o),
        .blk_oe_in(dbus_oe), .la_in(la), .en_n_in(en_n), .dir_in(dir), .maddr_in(maddr),
        .waits_in(waits), .dreq_in(dreq), .bus_out(dbus), .ready_out(ready), .dreq_out(dreq_w));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input string what, input [15:0] exp, input [15:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task close_out;
        begin
            $display("compared %0d mismatched %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // A bounded wait that ran out ends the run
    task tmo(input integer kk);
        if (kk >= 200)
        begin
            $display("ERROR wait expected event seen none");
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    endtask
    // One drive register access, random wait states from the drive
    task access(input w, input [1:0] b, input [2:0] r, input [15:0] d);
        begin
            rnd = lfsr(rnd);
            waits <= rnd[2:0] % 3'h7;
            la_drv <= rnd[10:4];
            expq.push_back({w, (7'h08 << b) | {4'h0, r}, d});
            req <= 1'b1;
            wr <= w;
            blk <= b;
            rg <= r;
            wdata <= d;
            for (k = 0; k < 200 && busy !== 1'b1; k = k + 1)
                @(posedge clk);
            tmo(k);
            req <= 1'b0;
            for (k = 0; k < 200 && done !== 1'b1; k = k + 1)
                @(posedge clk);
            tmo(k);
            check("expansion lines", {9'h0, la_drv}, {9'h0, la_o});
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Result watcher: oldest expectation against each completed access
    always @(posedge clk)
    begin
        if (done === 1'b1)
        begin
            e = expq.pop_front();
            if (e[23])
                check("stored word", e[15:0], u_model.mem[e[22:16]]);
            else
                check("read data", e[15:0], rdata);
        end
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        $display("ERROR run expected end seen hang");
        n_mismatch = n_mismatch + 1;
        close_out;
    end
    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        rnd = 32'hd3dad573;
        {rst_n, req, wr, xfer, mst} = 5'h0;
        {blk, act, dreq, rg, waits} = 12'h0;
        {wdata, upper, la_drv, la_ext, maddr} = 58'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("strobes", 16'h3, {14'h0, rd_n, wr_n});
        check("acks", 16'h3, {14'h0, ack_n});
        check("xcvr", 16'h3, {14'h0, en_n, dir});
        $display("test reset levels done");
        // Every block, edge addresses first, write then read back
        for (i = 0; i < 12; i = i + 1)
        begin
            rnd = lfsr(rnd);
            wd = rnd[31:16];
            rr = (i < 8) ? {3{i[2]}} : rnd[10:8];
            access(1'b1, i[1:0], rr, wd);
            access(1'b0, i[1:0], rr, wd);
        end
        $display("test drive registers done");
        rnd = lfsr(rnd);
        upper <= rnd[15:0];
        xfer <= 1'b1;
        for (k = 0; k < 200 && en_n !== 1'b0; k = k + 1)
            @(posedge clk);
        tmo(k);
        @(posedge clk);
        check("xfer bus", upper, dbus_o);
        check("intr select", {15'h0, upper[14]}, {15'h0, dbus[14]});
        check("xfer dir", 16'h1, {15'h0, dir});
        xfer <= 1'b0;
        $display("test outward transfer done");
        rnd = lfsr(rnd);
        maddr <= rnd[11:0];
        la_ext <= rnd[22:16];
        mst <= 1'b1;
        for (k = 0; k < 200 && dir !== 1'b0; k = k + 1)
            @(posedge clk);
        tmo(k);
        req <= 1'b1;
        repeat (6) @(posedge clk);
        check("master addr", {4'h0, maddr}, {4'h0, maddr_q});
        check("refused busy", 16'h0, {15'h0, busy});
        {mst, req} <= 2'h0;
        for (k = 0; k < 200 && dir !== 1'b1; k = k + 1)
            @(posedge clk);
        tmo(k);
        $display("test external master done");
        for (i = 0; i < 2; i = i + 1)
        begin
            dreq <= 2'h1 << i;
            repeat (8) @(posedge clk);
            check("ack idle", 16'h3, {14'h0, ack_n});
            act <= 2'h1 << i;
            for (k = 0; k < 200 && ack_n[i] !== 1'b0; k = k + 1)
                @(posedge clk);
            tmo(k);
            check("ack other", 16'h1, {15'h0, ack_n[1 - i]});
            check("bm request", {14'h0, 2'h1 << i}, {14'h0, bm_req});
            {dreq, act} <= 4'h0;
            for (k = 0; k < 200 && ack_n !== 2'h3; k = k + 1)
                @(posedge clk);
            tmo(k);
        end
        $display("test dma handshake done");
        close_out;
    end
endmodule // icpi_channel_pins_tb_top
